// >>> design/uid_regs.sv
// register slice of a uart: divisor latch, interrupt enable, interrupt
// identity and prioritised interrupt sources; assumes a simple word register
// port (address, read and write strobes), event pulses and an rx ready level from the datapath
`timescale 1ns/1ns
`include "uid_cfg.svh"
module uid_regs
    import uid_pkg::*;
(
    // clock and reset
    input wire logic i_sys_clk,
    input wire logic i_reset_n,
    // register port
    input wire logic [7:0] i_addr,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [31:0] i_wdata,
    output logic [31:0] o_rdata,
    // datapath events
    input wire logic i_line_error,
    input wire logic i_rx_ready,
    input wire logic i_tx_empty_event,
    input wire logic i_modem_change,
    // outputs
    output logic [7:0] o_line_control,
    output logic [15:0] o_divisor,
    output logic o_transmit_holding_wr,
    output logic o_receive_buffer_rd,
    output logic o_sample_tick,
    output logic o_baud_tick,
    output logic o_irq
);
    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    logic [7:0] line_control;
    logic [7:0] next_line_control;
    logic [7:0] divisor_latch_low;
    logic [7:0] next_divisor_latch_low;
    logic [7:0] divisor_latch_high;
    logic [7:0] next_divisor_latch_high;
    logic [3:0] interrupt_enable;
    logic [3:0] next_interrupt_enable;
    logic line_pend;
    logic next_line_pend;
    logic tx_pend;
    logic next_tx_pend;
    logic modem_pend;
    logic next_modem_pend;
    logic [31:0] next_rdata;
    logic [2:0] ident;
    logic [3:0] active;
    logic divisor_access_select;
    uid_src_e top_src;

    // ----------------------------------------------------------------
    // address decode
    // ----------------------------------------------------------------
    assign divisor_access_select = line_control[`UID_LCTL_DIV_ACCESS_BIT];
    wire logic rd_data = i_rd && i_addr == `UID_OFF_DATA && !divisor_access_select;
    wire logic wr_data = i_wr && i_addr == `UID_OFF_DATA && !divisor_access_select;
    wire logic rd_ident = i_rd && i_addr == `UID_OFF_IDENT;
    wire logic rd_lstat = i_rd && i_addr == `UID_OFF_LSTAT;
    wire logic rd_mstat = i_rd && i_addr == `UID_OFF_MSTAT;

    // ----------------------------------------------------------------
    // priority encoding
    // ----------------------------------------------------------------
    // rx pending is a level from the receiver, so it clears when data drains
    assign active = {modem_pend & interrupt_enable[`UID_IEN_MODEM_BIT],
                     tx_pend & interrupt_enable[`UID_IEN_TX_BIT],
                     i_rx_ready & interrupt_enable[`UID_IEN_RX_BIT],
                     line_pend & interrupt_enable[`UID_IEN_LINE_BIT]};

    always_comb begin
        top_src = UID_SRC_MODEM;
        ident = `UID_ID_NONE;
        if (active[0]) begin
            top_src = UID_SRC_LINE;
            ident = `UID_ID_LINE;
        end else if (active[1]) begin
            top_src = UID_SRC_RX;
            ident = `UID_ID_RX;
        end else if (active[2]) begin
            top_src = UID_SRC_TX;
            ident = `UID_ID_TX;
        end else if (active[3]) begin
            top_src = UID_SRC_MODEM;
            ident = `UID_ID_MODEM;
        end
    end

    assign o_irq = |active;

    // ----------------------------------------------------------------
    // next-state
    // ----------------------------------------------------------------
    always_comb begin
        next_line_control = line_control;
        next_divisor_latch_low = divisor_latch_low;
        next_divisor_latch_high = divisor_latch_high;
        next_interrupt_enable = interrupt_enable;
        if (i_wr) begin
            unique case (i_addr)
                `UID_OFF_DATA: begin
                    if (divisor_access_select) begin
                        next_divisor_latch_low = i_wdata[7:0];
                    end
                end
                `UID_OFF_IEN: begin
                    if (divisor_access_select) begin
                        next_divisor_latch_high = i_wdata[7:0];
                    end else begin
                        next_interrupt_enable = i_wdata[3:0];
                    end
                end
                `UID_OFF_LCTL: begin
                    next_line_control = i_wdata[7:0];
                end
                default: begin
                end
            endcase
        end
        // set wins over clear for every sticky source
        next_line_pend = i_line_error || (line_pend && !rd_lstat);
        next_modem_pend = i_modem_change || (modem_pend && !rd_mstat);
        next_tx_pend = i_tx_empty_event
            || (tx_pend && !wr_data && !(rd_ident && top_src == UID_SRC_TX
                && active[2]));
    end

    always_comb begin
        next_rdata = 32'h0000_0000;
        unique case (i_addr)
            `UID_OFF_DATA: next_rdata[7:0] = divisor_access_select ? divisor_latch_low : 8'h00;
            `UID_OFF_IEN: next_rdata[7:0] = divisor_access_select ? divisor_latch_high
                                                : {4'h0, interrupt_enable};
            `UID_OFF_IDENT: next_rdata[7:0] = {5'h00, ident};
            `UID_OFF_LCTL: next_rdata[7:0] = line_control;
            default: next_rdata = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_reset_n) begin
            line_control <= 8'h00;
            divisor_latch_low <= 8'(`UID_DIV_RESET);
            divisor_latch_high <= 8'(`UID_DIV_RESET >> 8);
            interrupt_enable <= 4'h0;
            line_pend <= 1'b0;
            tx_pend <= 1'b0;
            modem_pend <= 1'b0;
            o_rdata <= 32'h0000_0000;
            o_transmit_holding_wr <= 1'b0;
            o_receive_buffer_rd <= 1'b0;
        end else begin
            line_control <= next_line_control;
            divisor_latch_low <= next_divisor_latch_low;
            divisor_latch_high <= next_divisor_latch_high;
            interrupt_enable <= next_interrupt_enable;
            line_pend <= next_line_pend;
            tx_pend <= next_tx_pend;
            modem_pend <= next_modem_pend;
            o_rdata <= i_rd ? next_rdata : 32'h0000_0000;
            o_transmit_holding_wr <= wr_data;
            o_receive_buffer_rd <= rd_data;
        end
    end

    assign o_line_control = line_control;
    assign o_divisor = {divisor_latch_high, divisor_latch_low};

    uid_baud_gen i_uid_baud_gen (
        .i_sys_clk(i_sys_clk),
        .i_reset_n(i_reset_n),
        .i_divisor(o_divisor),
        .o_sample_tick(o_sample_tick),
        .o_baud_tick(o_baud_tick)
    );

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    property p_line_sets;
        @(posedge i_sys_clk) disable iff (!i_reset_n)
        i_line_error |=> line_pend;
    endproperty
    a_line_sets: assert property (p_line_sets)
        else $error("line error not latched");

    property p_line_clear;
        @(posedge i_sys_clk) disable iff (!i_reset_n)
        rd_lstat && !i_line_error |=> !line_pend;
    endproperty
    a_line_clear: assert property (p_line_clear)
        else $error("line status read did not clear");

    property p_modem_clear;
        @(posedge i_sys_clk) disable iff (!i_reset_n)
        rd_mstat && !i_modem_change |=> !modem_pend;
    endproperty
    a_modem_clear: assert property (p_modem_clear)
        else $error("modem status read did not clear");

    property p_tx_clear_write;
        @(posedge i_sys_clk) disable iff (!i_reset_n)
        wr_data && !i_tx_empty_event |=> !tx_pend;
    endproperty
    a_tx_clear_write: assert property (p_tx_clear_write)
        else $error("holding write did not clear tx empty");

    property p_ident_none;
        @(posedge i_sys_clk) disable iff (!i_reset_n)
        !o_irq |-> ident == `UID_ID_NONE;
    endproperty
    a_ident_none: assert property (p_ident_none)
        else $error("identity not none while idle");

    property p_line_top;
        @(posedge i_sys_clk) disable iff (!i_reset_n)
        line_pend && interrupt_enable[`UID_IEN_LINE_BIT] |-> ident == `UID_ID_LINE;
    endproperty
    a_line_top: assert property (p_line_top)
        else $error("line status not highest priority");

    property p_irq_level;
        @(posedge i_sys_clk) disable iff (!i_reset_n)
        o_irq == (ident != `UID_ID_NONE);
    endproperty
    a_irq_level: assert property (p_irq_level)
        else $error("irq disagrees with identity");

    property p_ien_write;
        @(posedge i_sys_clk) disable iff (!i_reset_n)
        i_wr && i_addr == `UID_OFF_IEN && !divisor_access_select
            |=> interrupt_enable == $past(i_wdata[3:0]);
    endproperty
    a_ien_write: assert property (p_ien_write)
        else $error("enable write lost");

    property p_dlh_write;
        @(posedge i_sys_clk) disable iff (!i_reset_n)
        i_wr && i_addr == `UID_OFF_IEN && divisor_access_select
            |=> o_divisor[15:8] == $past(i_wdata[7:0]) && $stable(interrupt_enable);
    endproperty
    a_dlh_write: assert property (p_dlh_write)
        else $error("divisor high write wrong");

    property p_modem_sets;
        @(posedge i_sys_clk) disable iff (!i_reset_n)
        i_modem_change |=> modem_pend;
    endproperty
    a_modem_sets: assert property (p_modem_sets)
        else $error("modem change not latched");

    property p_tx_sets;
        @(posedge i_sys_clk) disable iff (!i_reset_n)
        i_tx_empty_event |=> tx_pend;
    endproperty
    a_tx_sets: assert property (p_tx_sets)
        else $error("tx empty not latched");

    property p_tx_clear_ident;
        @(posedge i_sys_clk) disable iff (!i_reset_n)
        rd_ident && ident == `UID_ID_TX && !i_tx_empty_event |=> !tx_pend;
    endproperty
    a_tx_clear_ident: assert property (p_tx_clear_ident)
        else $error("identity read did not clear tx empty");

    property p_rx_second;
        @(posedge i_sys_clk) disable iff (!i_reset_n)
        i_rx_ready && interrupt_enable[`UID_IEN_RX_BIT] && !active[0] |-> ident == `UID_ID_RX;
    endproperty
    a_rx_second: assert property (p_rx_second)
        else $error("rx data not second priority");

    property p_enable_masks;
        @(posedge i_sys_clk) disable iff (!i_reset_n)
        interrupt_enable == 4'h0 |-> !o_irq;
    endproperty
    a_enable_masks: assert property (p_enable_masks)
        else $error("irq raised with all enables clear");

    property p_ident_read;
        @(posedge i_sys_clk) disable iff (!i_reset_n)
        rd_ident |=> o_rdata[2:0] == $past(ident);
    endproperty
    a_ident_read: assert property (p_ident_read)
        else $error("identity read data wrong");

    property p_divisor_hidden;
        @(posedge i_sys_clk) disable iff (!i_reset_n)
        i_wr && i_addr == `UID_OFF_DATA && !divisor_access_select |=> $stable(o_divisor);
    endproperty
    a_divisor_hidden: assert property (p_divisor_hidden)
        else $error("divisor changed with access bit clear");

    property p_buffer_read;
        @(posedge i_sys_clk) disable iff (!i_reset_n)
        rd_data |=> o_receive_buffer_rd;
    endproperty
    a_buffer_read: assert property (p_buffer_read)
        else $error("buffer read strobe missing");
endmodule // uid_regs

// >>> design/uid_cfg.svh
// register offsets, field positions, reset values and timing counts for the
// uart interrupt/divisor block; assumes word-wide register port at byte offsets
// Summary of operation
// - divisor high and low form 16-bit latch
// - baud equals clock over sixteen times divisor
// - enable register holds four read/write enables
// - identity read-only, 001 means none pending
// - line status 110 highest, cleared by status read
// - rx data 100 second, cleared by buffer read
// - tx empty 010 third, cleared identity read/write
// - modem status 000 lowest, cleared by status read
// - divisor-access bit redirects shared offsets
`ifndef UID_CFG_SVH
`define UID_CFG_SVH

// ----------------------------------------------------------------
// offsets
// ----------------------------------------------------------------
`define UID_OFF_DATA 8'h00
`define UID_OFF_IEN 8'h04
`define UID_OFF_IDENT 8'h08
`define UID_OFF_LCTL 8'h0C
`define UID_OFF_LSTAT 8'h14
`define UID_OFF_MSTAT 8'h18

// ----------------------------------------------------------------
// fields and values
// ----------------------------------------------------------------
`define UID_LCTL_DIV_ACCESS_BIT 7
`define UID_IEN_RX_BIT 0
`define UID_IEN_TX_BIT 1
`define UID_IEN_LINE_BIT 2
`define UID_IEN_MODEM_BIT 3
`define UID_ID_NONE 3'h1
`define UID_ID_LINE 3'h6
`define UID_ID_RX 3'h4
`define UID_ID_TX 3'h2
`define UID_ID_MODEM 3'h0
`define UID_DIV_RESET 16'h0001
`define UID_OVERSAMPLE 5'h10

`endif

// >>> design/uid_pkg.sv
// types shared by the uart interrupt/divisor block
package uid_pkg;
    typedef enum logic [1:0] {
        UID_SRC_LINE,
        UID_SRC_RX,
        UID_SRC_TX,
        UID_SRC_MODEM
    } uid_src_e;
endpackage

// >>> design/uid_baud_gen.sv
// baud tick generator: one tick per divisor clocks (16x oversample) and one
// baud tick per sixteen of those; assumes a single system clock
`timescale 1ns/1ns
`include "uid_cfg.svh"
module uid_baud_gen (
    // clock and reset
    input wire logic i_sys_clk,
    input wire logic i_reset_n,
    // divisor
    input wire logic [15:0] i_divisor,
    // ticks
    output logic o_sample_tick,
    output logic o_baud_tick
);
    logic [15:0] div_cnt;
    logic [15:0] next_div_cnt;
    logic [4:0] os_cnt;
    logic [4:0] next_os_cnt;
    logic next_sample;
    logic next_baud;

    always_comb begin
        next_div_cnt = div_cnt + 16'h0001;
        next_os_cnt = os_cnt;
        next_sample = 1'b0;
        next_baud = 1'b0;
        // divisor of zero holds the generator still rather than running wild
        if (i_divisor == 16'h0000) begin
            next_div_cnt = 16'h0000;
        end else if (next_div_cnt >= i_divisor) begin
            next_div_cnt = 16'h0000;
            next_sample = 1'b1;
            next_os_cnt = os_cnt + 5'h01;
            if (next_os_cnt == `UID_OVERSAMPLE) begin
                next_os_cnt = 5'h00;
                next_baud = 1'b1;
            end
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_reset_n) begin
            div_cnt <= 16'h0000;
            os_cnt <= 5'h00;
            o_sample_tick <= 1'b0;
            o_baud_tick <= 1'b0;
        end else begin
            div_cnt <= next_div_cnt;
            os_cnt <= next_os_cnt;
            o_sample_tick <= next_sample;
            o_baud_tick <= next_baud;
        end
    end

    property p_baud_after_sample;
        @(posedge i_sys_clk) disable iff (!i_reset_n)
        o_baud_tick |-> o_sample_tick;
    endproperty
    a_baud_after_sample: assert property (p_baud_after_sample)
        else $error("baud tick without sample tick");
endmodule // uid_baud_gen

// >>> verification/uid_datapath_model.sv
// datapath stand-in: raises the uart event inputs on request, counts strobes
// assumes the bench calls its tasks between clock edges
`timescale 1ns/1ns
module uid_datapath_model (
    // clock
    input wire logic i_sys_clk,
    // strobes from the block
    input wire logic i_transmit_holding_wr,
    input wire logic i_receive_buffer_rd,
    // events to the block
    output logic o_line_error,
    output logic o_rx_ready,
    output logic o_tx_empty_event,
    output logic o_modem_change
);
    int n_wr = 0;
    int n_rd = 0;
    initial begin
        o_line_error = 1'b0;
        o_rx_ready = 1'b0;
        o_tx_empty_event = 1'b0;
        o_modem_change = 1'b0;
    end
    // a buffer read drains the single held character
    always @(posedge i_sys_clk) begin
        if (i_transmit_holding_wr) n_wr++;
        if (i_receive_buffer_rd) n_rd++;
        if (i_receive_buffer_rd) o_rx_ready <= 1'b0;
    end
    // one-cycle event: 0 line error, 1 tx empty, 2 modem change
    task automatic pulse(input int which);
        @(negedge i_sys_clk);
        case (which)
            0: o_line_error = 1'b1;
            1: o_tx_empty_event = 1'b1;
            default: o_modem_change = 1'b1;
        endcase
        @(negedge i_sys_clk);
        o_line_error = 1'b0;
        o_tx_empty_event = 1'b0;
        o_modem_change = 1'b0;
    endtask
    task automatic set_rx();
        @(negedge i_sys_clk);
        o_rx_ready = 1'b1;
    endtask
endmodule // uid_datapath_model

// >>> verification/uid_regs_tb.sv
// self-checking bench for uid_regs with the datapath stand-in
// assumes a 100 MHz clock; inputs change on the falling edge
`timescale 1ns/1ns
`include "uid_cfg.svh"
module uid_regs_tb;
    logic i_sys_clk;
    logic i_reset_n = 1'b0;
    logic [7:0] i_addr = 8'h00;
    logic i_wr = 1'b0;
    logic i_rd = 1'b0;
    logic [31:0] i_wdata = 32'h0;
    logic [31:0] o_rdata;
    logic line_error, rx_ready, tx_empty_event, modem_change;
    logic [7:0] o_line_control;
    logic [15:0] o_divisor;
    logic hold_wr, buf_rd, o_sample_tick, o_baud_tick, o_irq;
    logic [31:0] rd_val;
    int fails = 0;
    int n_tests = 0;
    int cycles = 0;
    uid_regs i_uid_regs (.i_sys_clk(i_sys_clk), .i_reset_n(i_reset_n), .i_addr(i_addr),
        .i_wr(i_wr), .i_rd(i_rd), .i_wdata(i_wdata), .o_rdata(o_rdata),
        .i_line_error(line_error), .i_rx_ready(rx_ready),
        .i_tx_empty_event(tx_empty_event), .i_modem_change(modem_change),
        .o_line_control(o_line_control), .o_divisor(o_divisor),
        .o_transmit_holding_wr(hold_wr), .o_receive_buffer_rd(buf_rd),
        .o_sample_tick(o_sample_tick), .o_baud_tick(o_baud_tick), .o_irq(o_irq));
    uid_datapath_model i_uid_datapath_model (.i_sys_clk(i_sys_clk),
        .i_transmit_holding_wr(hold_wr), .i_receive_buffer_rd(buf_rd),
        .o_line_error(line_error), .o_rx_ready(rx_ready),
        .o_tx_empty_event(tx_empty_event), .o_modem_change(modem_change));
    // ----------------------------------------------------------------
    // clock, watchdog, helpers
    // ----------------------------------------------------------------
    initial begin
        i_sys_clk = 1'b0;
        forever #5 i_sys_clk = ~i_sys_clk;
    end
    // whole run needs well under a thousand cycles
    always @(posedge i_sys_clk) begin
        cycles++;
        if (cycles == 5000) begin
            fails++;
            end_of_test();
        end
    end
    task automatic end_of_test();
        $display("checks %0d, mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(negedge i_sys_clk);
        i_addr = a;
        i_wdata = d;
        i_wr = 1'b1;
        @(negedge i_sys_clk);
        i_wr = 1'b0;
    endtask
    // read data is registered: valid in the cycle after the strobe edge
    task automatic rd(input logic [7:0] a);
        @(negedge i_sys_clk);
        i_addr = a;
        i_rd = 1'b1;
        @(negedge i_sys_clk);
        i_rd = 1'b0;
        rd_val = o_rdata;
    endtask
    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_reset();
        rd(`UID_OFF_IEN);
        check("enable reset", rd_val, 32'h0);
        rd(`UID_OFF_IDENT);
        check("ident none", rd_val, 32'h1);
        check("divisor reset", {16'h0, o_divisor}, 32'h1);
        check("irq reset", {31'h0, o_irq}, 32'h0);
        wr(`UID_OFF_IDENT, 32'h6);
        rd(`UID_OFF_IDENT);
        check("ident read only", rd_val, 32'h1);
        rd(8'h1C);
        check("unmapped read", rd_val, 32'h0);
        $display("test reset done");
    endtask
    task automatic t_divisor();
        int n;
        wr(`UID_OFF_LCTL, 32'h80);
        check("line control", {24'h0, o_line_control}, 32'h80);
        wr(`UID_OFF_DATA, 32'h34);
        wr(`UID_OFF_IEN, 32'h12);
        check("divisor", {16'h0, o_divisor}, 32'h1234);
        rd(`UID_OFF_IEN);
        check("divisor high", rd_val, 32'h12);
        rd(`UID_OFF_DATA);
        check("divisor low", rd_val, 32'h34);
        wr(`UID_OFF_DATA, 32'h3);
        wr(`UID_OFF_IEN, 32'h0);
        wr(`UID_OFF_LCTL, 32'h0);
        rd(`UID_OFF_IEN);
        check("enable untouched", rd_val, 32'h0);
        wr(`UID_OFF_DATA, 32'h55);
        // strobe is registered, the model counts it one edge later
        @(negedge i_sys_clk);
        check("holding writes", i_uid_datapath_model.n_wr, 32'h1);
        n = 0;
        while (o_baud_tick !== 1'b1 && n < 200) begin
            @(negedge i_sys_clk);
            n++;
        end
        n = 0;
        do begin
            @(negedge i_sys_clk);
            n++;
        end while (o_baud_tick !== 1'b1 && n < 200);
        check("baud period", n, 32'h30);
        n = 0;
        do begin
            @(negedge i_sys_clk);
            n++;
        end while (o_sample_tick !== 1'b1 && n < 20);
        check("sample period", n, 32'h3);
        $display("test divisor done");
    endtask
    task automatic t_priority();
        wr(`UID_OFF_IEN, 32'h0F);
        rd(`UID_OFF_IEN);
        check("enable rw", rd_val, 32'h0F);
        i_uid_datapath_model.pulse(2);
        i_uid_datapath_model.pulse(1);
        i_uid_datapath_model.set_rx();
        i_uid_datapath_model.pulse(0);
        rd(`UID_OFF_IDENT);
        check("ident line", rd_val, 32'h6);
        rd(`UID_OFF_LSTAT);
        rd(`UID_OFF_IDENT);
        check("ident rx", rd_val, 32'h4);
        rd(`UID_OFF_DATA);
        // strobe is registered, the model counts it one edge later
        @(negedge i_sys_clk);
        check("buffer reads", i_uid_datapath_model.n_rd, 32'h1);
        rd(`UID_OFF_IDENT);
        check("ident tx", rd_val, 32'h2);
        rd(`UID_OFF_IDENT);
        check("ident modem", rd_val, 32'h0);
        check("irq modem", {31'h0, o_irq}, 32'h1);
        rd(`UID_OFF_MSTAT);
        rd(`UID_OFF_IDENT);
        check("ident cleared", rd_val, 32'h1);
        check("irq clear", {31'h0, o_irq}, 32'h0);
        $display("test priority done");
    endtask
    task automatic t_mask();
        wr(`UID_OFF_IEN, 32'h02);
        i_uid_datapath_model.pulse(1);
        check("irq tx", {31'h0, o_irq}, 32'h1);
        wr(`UID_OFF_IEN, 32'h0);
        check("irq masked", {31'h0, o_irq}, 32'h0);
        wr(`UID_OFF_IEN, 32'h02);
        check("irq unmasked", {31'h0, o_irq}, 32'h1);
        wr(`UID_OFF_DATA, 32'h41);
        check("irq after write", {31'h0, o_irq}, 32'h0);
        $display("test mask done");
    endtask
    initial begin
        repeat (20) @(negedge i_sys_clk);
        i_reset_n = 1'b1;
        t_reset();
        t_divisor();
        t_priority();
        t_mask();
        end_of_test();
    end
endmodule // uid_regs_tb
